//--- inc/fbp_map.svh
/*
  Register offsets, field positions, reset values and bus answers of the
  flash bus pin block. Included by the package and by the block itself.
*/
`ifndef FBP_MAP_SVH
`define FBP_MAP_SVH

`define FBP_AMAX 24
`define FBP_CTRL_OFF 8'h00
`define FBP_RCR_OFF 8'h04
`define FBP_RDATA_OFF 8'h08
`define FBP_STAT_OFF 8'h0c
`define FBP_WADDR_OFF 8'h10
`define FBP_WDATA_OFF 8'h14
`define FBP_WCNT_OFF 8'h18

`define FBP_CTRL_SYNC 0
`define FBP_CTRL_LOCKDN 1
`define FBP_RCR_WT 10
`define FBP_RCR_LAT_LSB 11
`define FBP_CTRL_RST 2'h0
`define FBP_RCR_RST 16'h0400

`define FBP_ST_BLOCKED 0
`define FBP_ST_DONE 1

`define FBP_RESP_OKAY 2'h0
`define FBP_RESP_SLVERR 2'h2

`endif

//--- inc/fbp_pkg.sv
/*
  Types of the flash bus pin block: bus carriers, pin bundle and the
  state records of the system and link clock domains.
  Assumes fbp_map.svh is on the include path.
*/
`include "fbp_map.svh"

package fbp_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fbp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fbp_axi_rsp_t;

  typedef struct packed {
    logic adv_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic wp_n;
    logic rst_n;
    logic vpp_lk;
    logic vcc_lk;
    logic [`FBP_AMAX-1:0] addr;
    logic [15:0] dq;
  } fbp_pins_t;

  typedef struct packed {
    logic sync;
    logic pol;
    logic [2:0] lat;
    logic rst;
  } fbp_cfg_t;

  typedef struct packed {
    fbp_pins_t p1;
    fbp_pins_t p2;
    logic we_q;
    logic [1:0] ctrl;
    logic [15:0] read_config_reg;
    logic [15:0] rdata;
    logic [1:0] stk;
    logic [`FBP_AMAX-1:0] waddr;
    logic [15:0] wdata;
    logic [15:0] wcnt;
    logic [`FBP_AMAX-1:0] cur_addr;
    logic wr_pulse;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } fbp_sys_t;

  typedef struct packed {
    fbp_cfg_t c1;
    fbp_cfg_t c2;
    logic busy;
    logic [2:0] lat;
    logic [`FBP_AMAX-1:0] cnt;
    logic wait_lvl;
  } fbp_lnk_t;

endpackage

//--- rtl/fbp_flash_bus.sv
/*
  Device-side logic behind the pins of a 16-bit parallel flash bus:
  address latching, output and wait enables, write capture and write
  inhibit, with an AXI4-Lite register port. Assumes the host drives
  address_valid_n, ce_n and addr in step with link_clk during burst
  reads; all other pins are treated as asynchronous to clk.
*/
`timescale 1ns/1ps
`include "fbp_map.svh"

module fbp_flash_bus #(
  parameter int AW = `FBP_AMAX
) (
  // system
  input logic clk,
  input logic rst,
  // register bus
  input fbp_pkg::fbp_axi_req_t axi_req,
  output fbp_pkg::fbp_axi_rsp_t axi_rsp,
  // flash bus clock
  input logic link_clk,
  // flash bus pins
  input logic [AW-1:0] addr_pin,
  input logic address_valid_n,
  input logic ce_n,
  input logic oe_n,
  input logic we_n,
  input logic wp_n,
  input logic flash_rst_n,
  input logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic wait_o,
  output logic wait_oe,
  // supply monitors, high while at or below lockout
  input logic program_supply_lockout,
  input logic core_lockout_level,
  // user side
  output logic [AW-1:0] cur_addr,
  output logic [AW-1:0] burst_addr,
  output logic wr_strobe,
  output logic [AW-1:0] wr_addr,
  output logic [15:0] wr_data
);

  fbp_pkg::fbp_sys_t s_reg;
  fbp_pkg::fbp_sys_t s_next;
  fbp_pkg::fbp_lnk_t l_reg;
  fbp_pkg::fbp_lnk_t l_next;
  fbp_pkg::fbp_pins_t pin_in;
  fbp_pkg::fbp_cfg_t cfg_src;
  logic we_rise;
  logic lock_eff;
  logic blocked;
  logic aw_take;
  logic w_take;
  logic ar_take;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = old;
    if (st[0])
    begin
      merge16[7:0] = d[7:0];
    end
    if (st[1])
    begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  always_comb
  begin
    pin_in.adv_n = address_valid_n;
    pin_in.ce_n = ce_n;
    pin_in.oe_n = oe_n;
    pin_in.we_n = we_n;
    pin_in.wp_n = wp_n;
    pin_in.rst_n = flash_rst_n;
    pin_in.vpp_lk = program_supply_lockout;
    pin_in.vcc_lk = core_lockout_level;
    pin_in.addr = `FBP_AMAX'(addr_pin);
    pin_in.dq = dq_i;
  end

  // lock-down only bites while write-protect is low
  assign lock_eff = s_reg.ctrl[`FBP_CTRL_LOCKDN] & ~s_reg.p2.wp_n;
  assign blocked = ~s_reg.p2.rst_n | s_reg.p2.vpp_lk | s_reg.p2.vcc_lk
                   | lock_eff;
  assign we_rise = ~s_reg.we_q & s_reg.p2.we_n & ~s_reg.p2.ce_n;
  assign aw_take = axi_req.awvalid & axi_rsp.awready;
  assign w_take = axi_req.wvalid & axi_rsp.wready;
  assign ar_take = axi_req.arvalid & axi_rsp.arready;

  always_comb
  begin
    axi_rsp.awready = ~s_reg.aw_have & ~s_reg.bvalid;
    axi_rsp.wready = ~s_reg.w_have & ~s_reg.bvalid;
    axi_rsp.bvalid = s_reg.bvalid;
    axi_rsp.bresp = s_reg.bresp;
    axi_rsp.arready = ~s_reg.rvalid;
    axi_rsp.rvalid = s_reg.rvalid;
    axi_rsp.rdata = s_reg.rdat;
    axi_rsp.rresp = s_reg.rresp;
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.p1 = pin_in;
    s_next.p2 = s_reg.p1;
    s_next.we_q = s_reg.p2.we_n;
    s_next.wr_pulse = 1'b0;
    if (!s_reg.p2.adv_n)
    begin
      s_next.cur_addr = s_reg.p2.addr;
    end
    if (aw_take)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = axi_req.awaddr;
    end
    if (w_take)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = axi_req.wdata;
      s_next.w_strb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `FBP_RESP_OKAY;
      case ({s_reg.aw_addr[7:2], 2'h0})
        `FBP_CTRL_OFF:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.ctrl = s_reg.w_data[1:0];
          end
        end
        `FBP_RCR_OFF:
          s_next.read_config_reg = merge16(s_reg.read_config_reg, s_reg.w_data, s_reg.w_strb);
        `FBP_RDATA_OFF:
          s_next.rdata = merge16(s_reg.rdata, s_reg.w_data, s_reg.w_strb);
        `FBP_STAT_OFF:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.stk = s_reg.stk & ~s_reg.w_data[1:0];
          end
        end
        `FBP_WADDR_OFF, `FBP_WDATA_OFF, `FBP_WCNT_OFF:
          s_next.bresp = `FBP_RESP_OKAY;
        default:
          s_next.bresp = `FBP_RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && axi_req.rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `FBP_RESP_OKAY;
      s_next.rdat = 32'h0;
      case ({axi_req.araddr[7:2], 2'h0})
        `FBP_CTRL_OFF:
          s_next.rdat[1:0] = s_reg.ctrl;
        `FBP_RCR_OFF:
          s_next.rdat[15:0] = s_reg.read_config_reg;
        `FBP_RDATA_OFF:
          s_next.rdat[15:0] = s_reg.rdata;
        `FBP_STAT_OFF:
          s_next.rdat[7:0] = {lock_eff, s_reg.p2.vcc_lk, s_reg.p2.vpp_lk,
                              s_reg.p2.wp_n, s_reg.p2.rst_n, 1'b0,
                              s_reg.stk};
        `FBP_WADDR_OFF:
          s_next.rdat[`FBP_AMAX-1:0] = s_reg.waddr;
        `FBP_WDATA_OFF:
          s_next.rdat[15:0] = s_reg.wdata;
        `FBP_WCNT_OFF:
          s_next.rdat[15:0] = s_reg.wcnt;
        default:
          s_next.rresp = `FBP_RESP_SLVERR;
      endcase
    end
    // a write edge after the status clear above wins over that clear
    if (we_rise)
    begin
      if (blocked)
      begin
        s_next.stk[`FBP_ST_BLOCKED] = 1'b1;
      end
      else
      begin
        s_next.waddr = s_reg.p2.addr;
        s_next.wdata = s_reg.p2.dq;
        s_next.wcnt = s_reg.wcnt + 16'h1;
        s_next.wr_pulse = 1'b1;
        s_next.stk[`FBP_ST_DONE] = 1'b1;
      end
    end
    // reset pin forces asynchronous read-array mode, overriding software
    if (!s_reg.p2.rst_n)
    begin
      s_next.ctrl[`FBP_CTRL_SYNC] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.p1 <= '1;
      s_reg.p2 <= '1;
      s_reg.we_q <= 1'b1;
      s_reg.ctrl <= `FBP_CTRL_RST;
      s_reg.read_config_reg <= `FBP_RCR_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // config levels only change on register writes, the reset pin or rst, so plain double
  // flops suffice; the latency field must not change mid-burst
  always_comb
  begin
    cfg_src.sync = s_reg.ctrl[`FBP_CTRL_SYNC];
    cfg_src.pol = s_reg.read_config_reg[`FBP_RCR_WT];
    cfg_src.lat = s_reg.read_config_reg[`FBP_RCR_LAT_LSB +: 3];
    cfg_src.rst = rst;
  end

  always_comb
  begin
    l_next = l_reg;
    l_next.c1 = cfg_src;
    l_next.c2 = l_reg.c1;
    if (ce_n)
    begin
      l_next.busy = 1'b0;
      l_next.lat = 3'h0;
    end
    else if (!address_valid_n && l_reg.c2.sync)
    begin
      l_next.cnt = `FBP_AMAX'(addr_pin);
      l_next.lat = l_reg.c2.lat;
      l_next.busy = 1'b1;
    end
    else if (l_reg.busy)
    begin
      l_next.cnt = l_reg.cnt + `FBP_AMAX'(1);
      if (l_reg.lat != 3'h0)
      begin
        l_next.lat = l_reg.lat - 3'h1;
      end
    end
    // asserted level equals the polarity bit
    if (l_next.busy && l_next.lat != 3'h0)
    begin
      l_next.wait_lvl = l_reg.c2.pol;
    end
    else
    begin
      l_next.wait_lvl = ~l_reg.c2.pol;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (l_reg.c2.rst)
    begin
      l_reg.c1 <= l_next.c1;
      l_reg.c2 <= l_next.c2;
      l_reg.busy <= 1'b0;
      l_reg.lat <= 3'h0;
      l_reg.cnt <= '0;
      l_reg.wait_lvl <= 1'b0;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // pin drivers; the link flop is only looked at while sync mode holds
  assign dq_oe = ~s_reg.p2.ce_n & ~s_reg.p2.oe_n & s_reg.p2.we_n;
  assign wait_oe = ~s_reg.p2.ce_n & ~s_reg.p2.oe_n;
  assign dq_o = s_reg.rdata;
  assign wait_o = (s_reg.ctrl[`FBP_CTRL_SYNC] & s_reg.p2.we_n)
                  ? l_reg.wait_lvl : ~s_reg.read_config_reg[`FBP_RCR_WT];
  assign cur_addr = s_reg.cur_addr[AW-1:0];
  assign burst_addr = l_reg.cnt[AW-1:0];
  assign wr_strobe = s_reg.wr_pulse;
  assign wr_addr = s_reg.waddr[AW-1:0];
  assign wr_data = s_reg.wdata;

  sequence s_edge_ok;
    we_rise && !blocked;
  endsequence

  sequence s_edge_bad;
    we_rise && blocked;
  endsequence

  a_standby_float: assert property (@(posedge clk) disable iff (rst)
    s_reg.p2.ce_n |-> !dq_oe && !wait_oe)
    else $error("outputs driven in standby");

  a_oe_float: assert property (@(posedge clk) disable iff (rst)
    s_reg.p2.oe_n |-> !dq_oe && !wait_oe)
    else $error("outputs driven with output enable high");

  a_write_capture: assert property (@(posedge clk) disable iff (rst)
    s_edge_ok |=> wr_strobe && wr_data == $past(s_reg.p2.dq)
                  && s_reg.waddr == $past(s_reg.p2.addr))
    else $error("write edge not captured");

  a_write_blocked: assert property (@(posedge clk) disable iff (rst)
    s_edge_bad |=> !wr_strobe && s_reg.stk[`FBP_ST_BLOCKED])
    else $error("blocked write was accepted");

  a_reset_async: assert property (@(posedge clk) disable iff (rst)
    !s_reg.p2.rst_n |=> !s_reg.ctrl[`FBP_CTRL_SYNC] [*2])
    else $error("sync mode kept during reset");

  a_vpp_lockout: assert property (@(posedge clk) disable iff (rst)
    we_rise && s_reg.p2.vpp_lk |=> $stable(s_reg.wcnt))
    else $error("write counted with program supply locked out");

  a_vcc_lockout: assert property (@(posedge clk) disable iff (rst)
    we_rise && s_reg.p2.vcc_lk |=> !wr_strobe)
    else $error("write passed with core supply locked out");

  a_lockdown_hold: assert property (@(posedge clk) disable iff (rst)
    we_rise && s_reg.ctrl[`FBP_CTRL_LOCKDN] && !s_reg.p2.wp_n
    |=> !wr_strobe)
    else $error("locked block changed with write-protect low");

  a_wp_override: assert property (@(posedge clk) disable iff (rst)
    we_rise && s_reg.p2.wp_n && s_reg.p2.rst_n && !s_reg.p2.vpp_lk
    && !s_reg.p2.vcc_lk |=> wr_strobe)
    else $error("write-protect high did not override lock-down");

  a_async_wait: assert property (@(posedge clk) disable iff (rst)
    wait_oe && (!s_reg.ctrl[`FBP_CTRL_SYNC] || !s_reg.p2.we_n)
    |-> wait_o == ~s_reg.read_config_reg[`FBP_RCR_WT])
    else $error("wait asserted outside sync reads");

  a_addr_flow: assert property (@(posedge clk) disable iff (rst)
    !s_reg.p2.adv_n ##1 s_reg.p2.adv_n |-> cur_addr == $past(addr_pin, 3))
    else $error("address not held at strobe rise");

  a_burst_load: assert property (@(posedge link_clk)
    disable iff (l_reg.c2.rst)
    !ce_n && !address_valid_n && l_reg.c2.sync
    |=> l_reg.cnt == $past(addr_pin))
    else $error("burst address not captured");

  a_burst_step: assert property (@(posedge link_clk)
    disable iff (l_reg.c2.rst)
    !ce_n && address_valid_n && l_reg.busy
    |=> l_reg.cnt == $past(l_reg.cnt) + `FBP_AMAX'(1))
    else $error("burst counter did not advance");

  a_wait_valid: assert property (@(posedge link_clk)
    disable iff (l_reg.c2.rst)
    l_reg.busy && l_reg.lat == 3'h0 |-> l_reg.wait_lvl == ~l_reg.c2.pol)
    else $error("wait asserted with data valid");

endmodule

//--- dv/fbp_host_model.sv
/*
  Host memory controller model that drives addr, adv_n, ce_n, oe_n, we_n and dq of the flash bus.
  Assumes clk and link_clk come from the bench; tasks are called from it.
*/
`timescale 1ns/1ps
module fbp_host_model (
  // clocks
  input wire logic clk,
  input wire logic link_clk,
  // pins toward the device
  output logic [23:0] addr,
  output logic adv_n,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [15:0] dq,
  output logic dq_en
);
  initial
  begin
    addr = 24'h0;
    adv_n = 1'b1;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    dq = 16'h0;
    dq_en = 1'b0;
  end

  // pins are sampled through synchronizers, so each level is held 5 clk
  task automatic ctl(input logic c, input logic o, input logic v,
                     input logic [23:0] a);
    ce_n <= c;
    oe_n <= o;
    adv_n <= v;
    addr <= a;
    repeat (5) @(posedge clk);
  endtask

  task automatic pin_write(input logic [23:0] a, input logic [15:0] d);
    ce_n <= 1'b0;
    oe_n <= 1'b1;
    adv_n <= 1'b0;
    addr <= a;
    dq <= d;
    dq_en <= 1'b1;
    we_n <= 1'b0;
    repeat (4) @(posedge clk);
    we_n <= 1'b1;
    // address and data stay put after the rise until it has been seen
    repeat (4) @(posedge clk);
    ce_n <= 1'b1;
    adv_n <= 1'b1;
    dq_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic burst_start(input logic [23:0] a);
    @(posedge link_clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    adv_n <= 1'b0;
    addr <= a;
    @(posedge link_clk);
    adv_n <= 1'b1;
  endtask

  task automatic burst_end();
    @(posedge link_clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
  endtask
endmodule

//--- dv/fbp_flash_bus_bench.sv
/*
  Bench of the flash bus pin block: register port, pin writes, write
  inhibit, output enables, address latch and bursts.
  Assumes the package, the block and the host model are compiled first.
*/
`timescale 1ns/1ps
`include "fbp_map.svh"
module fbp_flash_bus_bench;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic lclk_run = 1'b1;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic flash_rst_n = 1'b1;
  logic vpp_lk = 1'b0;
  logic vcc_lk = 1'b0;
  fbp_pkg::fbp_axi_req_t req = '0;
  fbp_pkg::fbp_axi_rsp_t rsp;
  logic [23:0] addr, cur_addr, burst_addr, wr_addr;
  logic [15:0] dq, dq_o, dq_i, wr_data;
  logic adv_n, ce_n, oe_n, we_n, dq_en, dq_oe, wait_o, wait_oe, wr_strobe;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [39:0] pq[$];
  logic [4:0] tbl [6] = '{5'h11, 5'h01, 5'h19, 5'h15, 5'h12, 5'h13};
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;
  // the link clock stands still outside reset and the burst test
  always #3 link_clk = lclk_run ? ~link_clk : 1'b0;
  // no pull-up on the data lines: a released bus reads back inverted
  assign dq_i = dq_oe ? dq_o : dq_en ? dq : ~dq;

  fbp_host_model u_host (.clk(clk), .link_clk(link_clk), .addr(addr),
    .adv_n(adv_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq),
    .dq_en(dq_en));

  fbp_flash_bus #(.AW(24)) u_fbp_flash_bus (.clk(clk), .rst(rst),
    .axi_req(req), .axi_rsp(rsp), .link_clk(link_clk), .addr_pin(addr),
    .address_valid_n(adv_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .wp_n(wp_n), .flash_rst_n(flash_rst_n), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .wait_o(wait_o), .wait_oe(wait_oe),
    .program_supply_lockout(vpp_lk), .core_lockout_level(vcc_lk),
    .cur_addr(cur_addr), .burst_addr(burst_addr), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data));

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    bq.push_back(r);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
      chk("bresp", 40'(bq.pop_front()), 40'(rsp.bresp));
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
      chk("rdata", 40'(rq.pop_front()), 40'({rsp.rresp, rsp.rdata}));
    if (wr_strobe === 1'b1)
      chk("pin write", pq.size() > 0 ? pq.pop_front() : 40'hx,
          {wr_addr, wr_data});
    if (cycles == 30000)
    begin
      fails++;
      print_verdict();
    end
  end

  initial
  begin
    logic [23:0] a;
    logic [15:0] d;
    logic [4:0] cs;
    int ok;
    logic [39:0] lw;
    ok = 0;
    void'($urandom(87701));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    lclk_run <= 1'b0;
    repeat (4) @(posedge clk);
    axr(`FBP_CTRL_OFF, 34'h0);
    axr(`FBP_RCR_OFF, 34'h400);
    axw(8'h40, 32'h0, `FBP_RESP_SLVERR);
    $display("test registers done");

    a = 24'($urandom);
    u_host.ctl(1'b1, 1'b1, 1'b0, a);
    chk("cur_addr", 40'(a), 40'(cur_addr));
    u_host.ctl(1'b1, 1'b1, 1'b1, a);
    u_host.ctl(1'b1, 1'b1, 1'b1, ~a);
    chk("cur_addr", 40'(a), 40'(cur_addr));
    $display("test address latch done");

    d = 16'($urandom);
    axw(`FBP_RDATA_OFF, 32'(d), `FBP_RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      u_host.ctl(i[1], i[0], 1'b1, a);
      chk("dq_oe", 40'(i == 0), 40'(dq_oe));
      chk("wait_oe", 40'(i == 0), 40'(wait_oe));
      if (i == 0) chk("dq_o", 40'(d), 40'(dq_o));
      if (i == 0) chk("wait_o", 40'h0, 40'(wait_o));
    end
    $display("test output enables done");

    for (int i = 0; i < 6; i++)
    begin
      cs = tbl[i];
      axw(`FBP_CTRL_OFF, 32'({cs[1], 1'b0}), `FBP_RESP_OKAY);
      flash_rst_n <= cs[4];
      vpp_lk <= cs[3];
      vcc_lk <= cs[2];
      wp_n <= cs[0];
      repeat (4) @(posedge clk);
      a = 24'($urandom);
      d = 16'($urandom);
      if (cs[4] && !cs[3] && !cs[2] && (!cs[1] || cs[0]))
      begin
        pq.push_back({a, d});
        lw = {a, d};
        ok++;
      end
      u_host.pin_write(a, d);
    end
    repeat (2) @(posedge clk);
    axr(`FBP_WCNT_OFF, 34'(ok));
    axr(`FBP_WADDR_OFF, 34'(lw[39:16]));
    axr(`FBP_WDATA_OFF, 34'(lw[15:0]));
    axr(`FBP_STAT_OFF, 34'h1b);
    axw(`FBP_STAT_OFF, 32'h3, `FBP_RESP_OKAY);
    axr(`FBP_STAT_OFF, 34'h18);
    $display("test write inhibit done");

    axw(`FBP_CTRL_OFF, 32'h3, `FBP_RESP_OKAY);
    flash_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    axr(`FBP_CTRL_OFF, 34'h2);
    flash_rst_n <= 1'b1;
    $display("test flash reset done");

    lclk_run <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      axw(`FBP_RCR_OFF, 32'h1000 | (32'(p) << 10), `FBP_RESP_OKAY);
      axw(`FBP_CTRL_OFF, 32'h1, `FBP_RESP_OKAY);
      repeat (8) @(posedge clk);
      a = 24'($urandom);
      u_host.burst_start(a);
      #1;
      chk("burst_addr", 40'(a), 40'(burst_addr));
      chk("wait_o", 40'(p), 40'(wait_o));
      @(posedge link_clk);
      #1;
      chk("wait_o", 40'(p), 40'(wait_o));
      @(posedge link_clk);
      #1;
      chk("wait_o", 40'(p == 0), 40'(wait_o));
      @(posedge link_clk);
      #1;
      chk("burst_addr", 40'(a + 24'h3), 40'(burst_addr));
      repeat (3) @(posedge link_clk);
      #1;
      chk("wait_o", 40'(p == 0), 40'(wait_o));
      u_host.burst_end();
    end
    lclk_run <= 1'b0;
    $display("test burst done");
    chk("pending writes", 40'h0, 40'(pq.size()));
    print_verdict();
  end
endmodule
